/* rtl/rtccd_pkg.sv */
package rtccd_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTL = 8'h00;
	localparam logic [7:0] OFS_DATE = 8'h04;
	localparam logic [7:0] OFS_TIME = 8'h08;
	// control field positions
	localparam int CTL_TRIM_LSB = 16;
	localparam int CTL_ON = 15;
	localparam int CTL_IDLE_HALT = 13;
	localparam int CTL_PIN_SEL = 7;
	localparam int CTL_CLK_RUN = 6;
	localparam int CTL_WR_UNLOCK = 3;
	localparam int CTL_HALF_SEC = 1;
	localparam int CTL_PIN_OE = 0;
	// time register seconds field
	localparam int TIME_SEC_LSB = 8;
	// date field positions
	localparam int DATE_YEAR_LSB = 24;
	localparam int DATE_MONTH_LSB = 16;
	localparam int DATE_DOM_LSB = 8;
	localparam int DATE_WDAY_LSB = 0;
	// writable masks of the control and date registers
	localparam logic [31:0] CTL_WMASK = 32'h03ff_a089;
	localparam logic [31:0] DATE_WMASK = 32'hff1f_3f07;
	// reset values
	localparam logic [9:0] TRIM_RST = 10'h000;
	localparam logic [31:0] DATE_RST = 32'h0000_0000;
	localparam logic [6:0] SEC_RST = 7'h00;
	// calendar clock pulses per second
	localparam int TICKS_PER_SEC = 32768;
	localparam logic [3:0] SEC_UNITS_MAX = 4'h9;
	localparam logic [2:0] SEC_TENS_MAX = 3'h5;

	// control bits held in flip-flops
	typedef struct packed {
		logic [9:0] trim;
		logic on;
		logic idle_halt;
		logic pin_sel;
		logic wr_unlock;
		logic pin_oe;
	} rtccd_ctl_type;

	// date fields
	typedef struct packed {
		logic [3:0] year_tens;
		logic [3:0] year_units;
		logic month_tens;
		logic [3:0] month_units;
		logic [1:0] dom_tens;
		logic [3:0] dom_units;
		logic [2:0] weekday_value;
	} rtccd_date_type;
endpackage

/* rtl/rtccd_prescale.sv */
`timescale 1ns/1ps
// divides calendar clock pulses to seconds and applies the per-minute trim
module rtccd_prescale #(
	parameter int TPS = rtccd_pkg::TICKS_PER_SEC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// control
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic i_minute,
	input wire logic [9:0] i_trim,
	// results
	output logic o_second,
	output logic o_half
);
	logic [16:0] cnt_r;
	logic signed [10:0] pend_r;
	logic [1:0] step;
	logic [16:0] sum;

	// a positive pending trim makes ticks count double, a negative one swallows them
	always_comb begin
		step = 2'h0;
		if (i_run && i_tick) begin
			if (pend_r > 11'sh000) begin
				step = 2'h2;
			end else if (pend_r < 11'sh000) begin
				step = 2'h0;
			end else begin
				step = 2'h1;
			end
		end
		sum = cnt_r + {15'h0000, step};
	end

	// second counter; clearing it also drops the half-second flag
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_r <= 17'h00000;
			o_second <= 1'b0;
			o_half <= 1'b0;
		end else if (i_ce) begin
			o_second <= 1'b0;
			if (i_clear) begin
				cnt_r <= 17'h00000;
				o_half <= 1'b0;
			end else if (sum >= 17'(TPS)) begin
				cnt_r <= sum - 17'(TPS);
				o_second <= 1'b1;
				o_half <= 1'b0;
			end else begin
				cnt_r <= sum;
				o_half <= (sum >= 17'(TPS / 2));
			end
		end
	end

	// trim pending count, reloaded at each minute boundary while running
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_r <= 11'sh000;
		end else if (i_ce) begin
			if (i_clear || !i_run) begin
				pend_r <= 11'sh000;
			end else if (i_minute) begin
				pend_r <= signed'({i_trim[9], i_trim});
			end else if (i_tick && pend_r > 11'sh000) begin
				pend_r <= pend_r - 11'sh001;
			end else if (i_tick && pend_r < 11'sh000) begin
				pend_r <= pend_r + 11'sh001;
			end
		end
	end

	// trim effects on the count; the bound keeps the step clear of the second wrap
	a_trim_double: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && i_run && i_tick && !i_clear && pend_r > 11'sh000 && cnt_r < 17'(TPS - 2)
		|=> cnt_r == $past(cnt_r) + 17'h00002)
		else $error("positive trim did not count a tick twice");
	a_trim_swallow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && i_run && i_tick && !i_clear && pend_r < 11'sh000 |=> $stable(cnt_r))
		else $error("negative trim did not swallow a tick");
	a_trim_load: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && i_run && !i_clear && i_minute
		|=> pend_r[9:0] == $past(i_trim) && pend_r[10] == pend_r[9])
		else $error("trim not loaded at minute boundary");
	a_trim_off_idle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && !i_run |=> pend_r == 11'sh000)
		else $error("trim pending while disabled");
endmodule

/* rtl/rtccd_top.sv */
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// calendar control and date block behind an APB slave
module rtccd_top #(
	parameter int TPS = rtccd_pkg::TICKS_PER_SEC
) (
	// clock, power-on reset, clock enable
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// non power-on reset, synchronous, active high
	input wire logic i_sys_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// system side
	input wire logic i_wr_seq_en,
	input wire logic i_idle,
	input wire logic i_cal_tick,
	input wire logic i_alarm_pulse,
	// calendar pin and run status
	output logic o_cal_pin,
	output logic o_clk_running
);
	rtccd_pkg::rtccd_ctl_type ctl_r;
	rtccd_pkg::rtccd_date_type date_r;
	logic [6:0] sec_r;
	logic [6:0] sec_nxt;
	logic minute_r;
	logic running;
	logic second;
	logic half;
	logic access;
	logic wr_en;
	logic sel_ctl;
	logic sel_date;
	logic sel_time;
	logic time_wr;
	logic [31:0] ctl_word;
	logic [31:0] rd_nxt;

	// decoding shared by the read mux and write enables
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	assign access = i_psel && i_penable;
	assign wr_en = access && o_pready && i_pwrite;
	assign sel_ctl = hit(i_paddr, rtccd_pkg::OFS_CTL);
	assign sel_date = hit(i_paddr, rtccd_pkg::OFS_DATE);
	assign sel_time = hit(i_paddr, rtccd_pkg::OFS_TIME);
	assign time_wr = wr_en && sel_time && ctl_r.wr_unlock;

	// calendar runs only when enabled and not halted by idle
	assign running = ctl_r.on && !(ctl_r.idle_halt && i_idle);

	// control word as software sees it; unimplemented bits stay zero
	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[rtccd_pkg::CTL_TRIM_LSB +: 10] = ctl_r.trim;
		ctl_word[rtccd_pkg::CTL_ON] = ctl_r.on;
		ctl_word[rtccd_pkg::CTL_IDLE_HALT] = ctl_r.idle_halt;
		ctl_word[rtccd_pkg::CTL_PIN_SEL] = ctl_r.pin_sel;
		ctl_word[rtccd_pkg::CTL_CLK_RUN] = o_clk_running;
		ctl_word[rtccd_pkg::CTL_WR_UNLOCK] = ctl_r.wr_unlock;
		ctl_word[rtccd_pkg::CTL_HALF_SEC] = half;
		ctl_word[rtccd_pkg::CTL_PIN_OE] = ctl_r.pin_oe;
	end

	// read mux; the answer is registered so pready lags setup by one wait state
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (sel_ctl) begin
			rd_nxt = ctl_word;
		end else if (sel_date) begin
			rd_nxt = {date_r.year_tens, date_r.year_units, 3'h0, date_r.month_tens,
				date_r.month_units, 2'h0, date_r.dom_tens, date_r.dom_units,
				5'h00, date_r.weekday_value};
		end else if (sel_time) begin
			rd_nxt = {17'h00000, sec_r, 8'h00};
		end
	end

	// apb handshake: one wait cycle, then pready for one cycle
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else if (i_ce) begin
			if (access && !o_pready) begin
				o_pready <= 1'b1;
				o_pslverr <= !(sel_ctl || sel_date || sel_time);
				o_prdata <= i_pwrite ? 32'h0000_0000 : rd_nxt;
			end else begin
				o_pready <= 1'b0;
				o_pslverr <= 1'b0;
			end
		end
	end

	// control register: only the power-on reset touches it, never the system reset
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctl_r <= '{trim: rtccd_pkg::TRIM_RST, default: 1'b0};
		end else if (i_ce && wr_en && sel_ctl) begin
			ctl_r.trim <= i_pwdata[rtccd_pkg::CTL_TRIM_LSB +: 10];
			ctl_r.idle_halt <= i_pwdata[rtccd_pkg::CTL_IDLE_HALT];
			ctl_r.pin_sel <= i_pwdata[rtccd_pkg::CTL_PIN_SEL];
			ctl_r.pin_oe <= i_pwdata[rtccd_pkg::CTL_PIN_OE];
			// enable is guarded by the unlock value held before this write
			if (ctl_r.wr_unlock) begin
				ctl_r.on <= i_pwdata[rtccd_pkg::CTL_ON];
			end
			// unlock can always be cleared but only set inside the write sequence
			if (!i_pwdata[rtccd_pkg::CTL_WR_UNLOCK] || i_wr_seq_en) begin
				ctl_r.wr_unlock <= i_pwdata[rtccd_pkg::CTL_WR_UNLOCK];
			end
		end
	end

	// date register, locked unless unlock is set
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			date_r <= rtccd_pkg::rtccd_date_type'(22'(rtccd_pkg::DATE_RST));
		end else if (i_ce) begin
			if (i_sys_rst) begin
				date_r <= rtccd_pkg::rtccd_date_type'(22'(rtccd_pkg::DATE_RST));
			end else if (wr_en && sel_date && ctl_r.wr_unlock) begin
				date_r.year_tens <= i_pwdata[rtccd_pkg::DATE_YEAR_LSB + 4 +: 4];
				date_r.year_units <= i_pwdata[rtccd_pkg::DATE_YEAR_LSB +: 4];
				date_r.month_tens <= i_pwdata[rtccd_pkg::DATE_MONTH_LSB + 4];
				date_r.month_units <= i_pwdata[rtccd_pkg::DATE_MONTH_LSB +: 4];
				date_r.dom_tens <= i_pwdata[rtccd_pkg::DATE_DOM_LSB + 4 +: 2];
				date_r.dom_units <= i_pwdata[rtccd_pkg::DATE_DOM_LSB +: 4];
				date_r.weekday_value <= i_pwdata[rtccd_pkg::DATE_WDAY_LSB +: 3];
			end
		end
	end

	// bcd seconds; wrap from 59 marks the minute boundary
	always_comb begin
		sec_nxt = sec_r;
		if (sec_r[3:0] < rtccd_pkg::SEC_UNITS_MAX) begin
			sec_nxt[3:0] = sec_r[3:0] + 4'h1;
		end else if (sec_r[6:4] < rtccd_pkg::SEC_TENS_MAX) begin
			sec_nxt = {sec_r[6:4] + 3'h1, 4'h0};
		end else begin
			sec_nxt = rtccd_pkg::SEC_RST;
		end
	end

	// seconds field, writable while unlocked; the write restarts the second
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sec_r <= rtccd_pkg::SEC_RST;
			minute_r <= 1'b0;
		end else if (i_ce) begin
			minute_r <= 1'b0;
			if (i_sys_rst) begin
				sec_r <= rtccd_pkg::SEC_RST;
			end else if (time_wr) begin
				sec_r <= i_pwdata[rtccd_pkg::TIME_SEC_LSB +: 7];
			end else if (second) begin
				sec_r <= sec_nxt;
				minute_r <= (sec_nxt == rtccd_pkg::SEC_RST);
			end
		end
	end

	rtccd_prescale #(
		.TPS(TPS)
	) u_prescale (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_ce(i_ce),
		.i_clear(i_sys_rst || time_wr),
		.i_run(running),
		.i_tick(i_cal_tick),
		.i_minute(minute_r),
		.i_trim(ctl_r.trim),
		.o_second(second),
		.o_half(half)
	);

	// pin and status outputs are registered; the pin is quiet unless enabled
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cal_pin <= 1'b0;
			o_clk_running <= 1'b0;
		end else if (i_ce) begin
			o_clk_running <= running;
			o_cal_pin <= ctl_r.pin_oe && (ctl_r.pin_sel ? half : i_alarm_pulse);
		end
	end

	// checks on the guarded behaviour
	a_pin_quiet_off: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && !ctl_r.pin_oe |=> !o_cal_pin)
		else $error("pin active while output disabled");
	a_pin_alarm_src: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && ctl_r.pin_oe && !ctl_r.pin_sel |=> o_cal_pin == $past(i_alarm_pulse))
		else $error("pin does not follow alarm pulse");
	a_pin_sec_src: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && ctl_r.pin_oe && ctl_r.pin_sel |=> o_cal_pin == $past(half))
		else $error("pin does not follow seconds clock");
	a_on_locked: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && wr_en && sel_ctl && !ctl_r.wr_unlock |=> $stable(ctl_r.on))
		else $error("enable changed while locked");
	a_unlock_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		$rose(ctl_r.wr_unlock) |-> $past(i_wr_seq_en) && $past(wr_en))
		else $error("unlock set outside write sequence");
	a_date_locked: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		!ctl_r.wr_unlock && !i_sys_rst ##1 !$past(ctl_r.wr_unlock) |-> $stable(date_r))
		else $error("date changed while locked");
	a_upper_ctl_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && access && !o_pready && !i_pwrite && sel_ctl |=> o_prdata[31:26] == 6'h00)
		else $error("upper control bits read nonzero");
	a_run_status: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && ctl_r.on && ctl_r.idle_halt && i_idle |=> !o_clk_running)
		else $error("status shows running in halted idle");
	a_half_cleared: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && time_wr |=> !half ##1 !ctl_word[rtccd_pkg::CTL_HALF_SEC] || i_cal_tick)
		else $error("half-second flag kept after seconds write");
	// bus answer is a single-cycle pulse; a request held past it is answered again after another wait cycle
	a_pready_pulse: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && o_pready |=> !o_pready)
		else $error("pready held longer than one cycle");
	a_run_needs_on: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && !ctl_r.on |=> !o_clk_running)
		else $error("status shows running while disabled");
	a_ctl_kept_sys: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && i_sys_rst && !(wr_en && sel_ctl) |=> $stable(ctl_r))
		else $error("control changed on system reset");
	a_date_pad_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		i_ce && access && !o_pready && !i_pwrite && sel_date
		|=> o_prdata[23:21] == 3'h0 && o_prdata[15:14] == 2'h0 && o_prdata[7:3] == 5'h00)
		else $error("unused date bits read nonzero");
endmodule

/* tb/tb_rtccd_top.sv */
`timescale 1ns/1ps
// self-checking bench for the calendar control and date block
module tb_rtccd_top;
	// short second so the half-second pin can be seen quickly
	localparam int TPS = 8;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_sys_rst = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic i_wr_seq_en = 1'b0;
	logic i_idle = 1'b0;
	logic i_cal_tick = 1'b0;
	logic i_alarm_pulse = 1'b0;
	logic tick_en = 1'b0;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic o_cal_pin;
	logic o_clk_running;
	logic [31:0] q;
	logic e;
	int n_mismatch = 0;
	int checked = 0;
	int tick_cnt = 0;

	rtccd_top #(.TPS(TPS)) rtccd_top_i (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_sys_rst(i_sys_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_wr_seq_en(i_wr_seq_en), .i_idle(i_idle), .i_cal_tick(i_cal_tick),
		.i_alarm_pulse(i_alarm_pulse), .o_cal_pin(o_cal_pin), .o_clk_running(o_clk_running)
	);

	// clock at 20 MHz
	always #25 i_clock = ~i_clock;

	// calendar pulse every fourth cycle, only while enabled
	always @(posedge i_clock) begin
		tick_cnt <= (tick_cnt + 1) % 4;
		i_cal_tick <= tick_en && (tick_cnt == 0);
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk1(input string nm, input logic exp, input logic got);
		chk32(nm, {31'h0, exp}, {31'h0, got});
	endtask

	// one apb transfer; held until pready is seen high at a rising edge, released right after
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		@(posedge i_clock);
		while (o_pready !== 1'b1 && n < 20) begin
			@(posedge i_clock);
			n++;
		end
		if (n == 20) chk1("pready", 1'b1, 1'b0);
		q = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk32(nm, exp, q);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	// reset state and locked writes
	task automatic t_lock;
		rd("ctl_rst", rtccd_pkg::OFS_CTL, 32'h0000_0000);
		rd("date_rst", rtccd_pkg::OFS_DATE, rtccd_pkg::DATE_RST);
		apb(1'b1, rtccd_pkg::OFS_DATE, 32'h1234_0506);
		rd("date_locked", rtccd_pkg::OFS_DATE, rtccd_pkg::DATE_RST);
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_8001);
		rd("on_locked", rtccd_pkg::OFS_CTL, 32'h0000_0001);
		chk1("run_off", 1'b0, o_clk_running);
	endtask

	// unlock needs the system write sequence
	task automatic t_unlock;
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_0008);
		rd("unlock_refused", rtccd_pkg::OFS_CTL, 32'h0000_0000);
		i_wr_seq_en <= 1'b1;
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_0008);
		rd("unlock_set", rtccd_pkg::OFS_CTL, 32'h0000_0008);
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'hffff_ffff);
		rd("ctl_mask", rtccd_pkg::OFS_CTL, 32'h03ff_a0c9);
		chk1("run_on", 1'b1, o_clk_running);
		i_idle <= 1'b1;
		wait_cyc(3);
		chk1("run_idle", 1'b0, o_clk_running);
		i_idle <= 1'b0;
		wait_cyc(3);
		chk1("run_wake", 1'b1, o_clk_running);
	endtask

	// bcd date fields and their unused bits
	task automatic t_date;
		apb(1'b1, rtccd_pkg::OFS_DATE, 32'h9919_3906);
		rd("date_val", rtccd_pkg::OFS_DATE, 32'h9919_3906);
		apb(1'b1, rtccd_pkg::OFS_DATE, 32'hffff_ffff);
		rd("date_mask", rtccd_pkg::OFS_DATE, rtccd_pkg::DATE_WMASK);
	endtask

	// pin source, pin enable and the half-second flag
	task automatic t_pin;
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_8009);
		i_alarm_pulse <= 1'b1;
		wait_cyc(3);
		chk1("pin_alarm", 1'b1, o_cal_pin);
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_8008);
		wait_cyc(2);
		chk1("pin_oe_off", 1'b0, o_cal_pin);
		i_alarm_pulse <= 1'b0;
		tick_en <= 1'b1;
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_8089);
		apb(1'b1, rtccd_pkg::OFS_TIME, 32'h0000_0500);
		wait_cyc(2);
		chk1("pin_half_clr", 1'b0, o_cal_pin);
		rd("half_clr", rtccd_pkg::OFS_CTL, 32'h0000_80c9);
		wait_cyc(18);
		chk1("pin_half_set", 1'b1, o_cal_pin);
	endtask

	// non power-on reset keeps control, clears date; unmapped access
	task automatic t_sys;
		@(posedge i_clock);
		i_sys_rst <= 1'b1;
		@(posedge i_clock);
		i_sys_rst <= 1'b0;
		tick_en <= 1'b0;
		rd("ctl_kept", rtccd_pkg::OFS_CTL, 32'h0000_80c9);
		rd("date_clr", rtccd_pkg::OFS_DATE, rtccd_pkg::DATE_RST);
		rd("bad_addr", 8'h10, 32'h0000_0000);
		chk1("bad_err", 1'b1, e);
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0000_0008);
		wait_cyc(3);
		chk1("run_stop", 1'b0, o_clk_running);
	endtask

	// trim of +4: the second after the 59 wrap takes 4 ticks, not 8
	task automatic t_trim;
		tick_en <= 1'b1;
		apb(1'b1, rtccd_pkg::OFS_CTL, 32'h0004_8008);
		apb(1'b1, rtccd_pkg::OFS_TIME, 32'h0000_5900);
		wait_cyc(52);
		rd("trim_fast", rtccd_pkg::OFS_TIME, 32'h0000_0100);
	endtask

	// watchdog
	initial begin
		#(20000 * 50);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		repeat (8) @(posedge i_clock);
		i_arst_n <= 1'b1;
		t_lock();
		t_unlock();
		t_date();
		t_pin();
		t_sys();
		t_trim();
		end_of_test();
	end
endmodule
